// file: testbench/phybc_bank_props.sv
// Concurrent checks on the PHY register bank ports
`timescale 1ns/1ps
`include "phybc_regs.svh"

module phybc_bank_props (
    // Clock, reset and bus
    input wire logic        core_clk,
    input wire logic        reset,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // Straps and core side
    input wire logic        speed_strap,
    input wire logic        an_enable_strap,
    input wire logic        soft_reset,
    input wire logic        loopback_en,
    input wire logic        link_drop,
    input wire logic [1:0]  speed_sel,
    input wire logic        speed_reserved,
    input wire logic        an_enable,
    input wire logic        an_restart,
    input wire logic        power_down
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    // Acknowledged write of the control reset bit
    sequence ctl_reset_write;
        wb_ack_o && wb_we_i && wb_adr_i == 8'h00 &&
            wb_sel_i[1:0] == 2'h3 && wb_dat_i[15];
    endsequence

    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged in the next cycle");
    AST_UPPER_ZERO: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
        else $error("upper read data not zero");
    AST_SWRST_START: assert property (ctl_reset_write |-> ##[0:1] soft_reset)
        else $error("soft reset did not start on write");
    AST_LOOP_LINK: assert property (link_drop == (loopback_en || power_down))
        else $error("link drop does not follow loopback");
    AST_SPEED_RSV: assert property (speed_reserved == speed_sel[1])
        else $error("reserved speed flag wrong");
    AST_STRAP_LOAD: assert property ($fell(reset) |=> an_enable == $past(an_enable_strap) && speed_sel == ($past(an_enable_strap) ? `PHYBC_SPEED_100 : {1'b0, $past(speed_strap)}))
        else $error("strap values not loaded");
    AST_PWRUP_RESET: assert property ($fell(power_down) |-> ##[0:2] soft_reset)
        else $error("no soft reset on leaving power-down");
    AST_PWRUP_RESTART: assert property ($fell(power_down) |-> ##[0:3] an_restart)
        else $error("no restart on leaving power-down");
    AST_RESTART_PULSE: assert property (an_restart |=> !an_restart)
        else $error("restart pulse too long");
endmodule : phybc_bank_props

bind phybc_bank phybc_bank_props phybc_bank_props_i (.core_clk(core_clk),
    .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .speed_strap(speed_strap),
    .an_enable_strap(an_enable_strap), .soft_reset(soft_reset),
    .loopback_en(loopback_en), .link_drop(link_drop), .speed_sel(speed_sel),
    .speed_reserved(speed_reserved), .an_enable(an_enable),
    .an_restart(an_restart), .power_down(power_down));

// file: testbench/phybc_bank_tb.sv
// Self-checking bench for the PHY register bank
`timescale 1ns/1ps

module phybc_bank_tb;
    logic        core_clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic        speed_strap, an_enable_strap, rx_error_pulse, soft_reset;
    logic        loopback_en, link_drop, speed_reserved, an_enable;
    logic        an_restart, power_down, irq;
    logic [1:0]  speed_sel;
    logic [15:0] partner_ability, vendor_status, cable_status;
    int          err_count = 0;
    int          comparisons = 0;
    logic [7:0]  rw_adr [7] = '{8'h10, 8'h40, 8'h48, 8'h50, 8'h58, 8'h60, 8'h64};

    phybc_bank phybc_bank_i (.core_clk(core_clk), .reset(reset),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .speed_strap(speed_strap),
        .an_enable_strap(an_enable_strap), .rx_error_pulse(rx_error_pulse),
        .partner_ability(partner_ability), .vendor_status(vendor_status),
        .cable_status(cable_status), .soft_reset(soft_reset),
        .loopback_en(loopback_en), .link_drop(link_drop),
        .speed_sel(speed_sel), .speed_reserved(speed_reserved),
        .an_enable(an_enable), .an_restart(an_restart),
        .power_down(power_down), .irq(irq));
    phybc_core_model phybc_core_model_i (.core_clk(core_clk),
        .rx_error_pulse(rx_error_pulse), .partner_ability(partner_ability),
        .vendor_status(vendor_status), .cable_status(cable_status));

    // Verdict and end of run
    task automatic end_sim;
        if (err_count == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_sim

    // Compare a register word and a single flag
    task automatic chk_reg(input string name, input logic [15:0] exp, got);
        comparisons++;
        if (got !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
            err_count++;
        end
    endtask : chk_reg
    task automatic chk_bit(input string name, input logic exp, got);
        @(negedge core_clk);
        comparisons++;
        if (got !== exp)
        begin
            $display("MISMATCH %s expected %b seen %b", name, exp, got);
            err_count++;
        end
    endtask : chk_bit

    // One classic Wishbone cycle, held until ack is sampled
    task automatic wb_xfer(input logic we, input logic [7:0] adr,
                           input logic [15:0] data, input logic [3:0] sel,
                           output logic [15:0] rd);
        int n;
        @(posedge core_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, we};
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= {16'h0000, data};
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 50);
        if (wb_ack_o !== 1'b1)
        begin
            err_count++;
            end_sim();
        end
        rd = wb_dat_o[15:0];
        {wb_cyc_i, wb_stb_i} <= 2'h0;
    endtask : wb_xfer
    task automatic wr(input logic [7:0] adr, input logic [15:0] data);
        logic [15:0] d;
        wb_xfer(1'b1, adr, data, 4'hF, d);
    endtask : wr
    task automatic rd_chk(input string name, input logic [7:0] adr,
                          input logic [15:0] exp);
        logic [15:0] d;
        wb_xfer(1'b0, adr, 16'h0000, 4'hF, d);
        chk_reg(name, exp, d);
    endtask : rd_chk

    // Clock
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // Main sequence
    initial
    begin
        logic [15:0] d;
        {reset, wb_cyc_i, wb_stb_i, wb_we_i, speed_strap} = 5'h10;
        {wb_adr_i, wb_sel_i, wb_dat_i, an_enable_strap} = 45'h1;
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        rd_chk("control", 8'h00, 16'h3000);
        rd_chk("status", 8'h04, 16'h7809);
        rd_chk("partner", 8'h14, partner_ability);
        rd_chk("vstatus", 8'h44, vendor_status);
        rd_chk("cable", 8'h70, cable_status);
        for (int i = 0; i < 7; i++)
            wr(rw_adr[i], 16'hA5C3 ^ 16'(i * 16'h1111));
        wb_xfer(1'b1, 8'h10, 16'h0F0F, 4'h0, d);
        for (int i = 0; i < 7; i++)
            rd_chk("rw_reg", rw_adr[i], 16'hA5C3 ^ 16'(i * 16'h1111));
        wr(8'h74, 16'h0003);
        wr(8'h78, 16'hBEEF);
        wr(8'h74, 16'h0004);
        wr(8'h78, 16'h1234);
        wr(8'h74, 16'h0003);
        rd_chk("ext_data", 8'h78, 16'hBEEF);
        wr(8'h1C, 16'hFFFF);
        rd_chk("unmapped", 8'h1C, 16'h0000);
        wr(8'h00, 16'h5040);
        rd_chk("ctl_loop", 8'h00, 16'h5000);
        chk_bit("loopback_en", 1'b1, loopback_en);
        chk_bit("link_drop", 1'b1, link_drop);
        wr(8'h00, 16'h2000);
        rd_chk("ctl_speed", 8'h00, 16'h2000);
        chk_reg("speed", 16'h0001, {14'h0, speed_sel});
        chk_bit("an_enable", 1'b0, an_enable);
        chk_bit("speed_rsv", 1'b0, speed_reserved);
        wr(8'h00, 16'hA000);
        chk_bit("soft_reset", 1'b1, soft_reset);
        chk_bit("loop_clear", 1'b0, loopback_en);
        rd_chk("ctl_swrst", 8'h00, 16'h2000);
        wr(8'h00, 16'h0800);
        chk_bit("power_down", 1'b1, power_down);
        wr(8'h00, 16'h0000);
        chk_bit("mask_off", 1'b0, irq);
        wr(8'h80, 16'h0007);
        chk_bit("irq_on", 1'b1, irq);
        rd_chk("sticky", 8'h7C, 16'h0006);
        chk_bit("irq_clear", 1'b0, irq);
        phybc_core_model_i.pulse_rx(2);
        repeat (4) @(posedge core_clk);
        rd_chk("rx_errors", 8'h54, 16'h0002);
        chk_bit("irq_rx", 1'b1, irq);
        rd_chk("irq_status", 8'h4C, 16'h0001);
        rd_chk("irq_status_clr", 8'h4C, 16'h0000);
        rd_chk("sticky_rx", 8'h7C, 16'h0001);
        end_sim();
    end
endmodule : phybc_bank_tb

// file: testbench/phybc_core_model.sv
// Behavioural model of the PHY core beside the register bank
`timescale 1ns/1ps

module phybc_core_model (
    // Clock
    input  wire logic        core_clk,
    // Core status towards the bank
    output logic             rx_error_pulse,
    output logic [15:0]      partner_ability,
    output logic [15:0]      vendor_status,
    output logic [15:0]      cable_status
);
    // Fixed status words, distinct so a swapped index shows
    initial
    begin
        rx_error_pulse  = 1'b0;
        partner_ability = 16'h45E1;
        vendor_status   = 16'h6C02;
        cable_status    = 16'h0B3A;
    end

    // Receive errors as wide pulses so the synchroniser sees each one
    task automatic pulse_rx(input int count);
        repeat (count)
        begin
            @(posedge core_clk) rx_error_pulse <= 1'b1;
            repeat (3) @(posedge core_clk);
            rx_error_pulse <= 1'b0;
            repeat (3) @(posedge core_clk);
        end
    endtask : pulse_rx
endmodule : phybc_core_model

// file: verilog/phybc_bank.sv
// PHY management register bank with Wishbone slave and interrupt
//
// Functional notes
// RL1: Writing one to the control reset bit starts a partial reset at once.
// RL2: The control reset bit clears itself so reads return zero afterwards.
// RL3: Loopback bit one loops MII transmit to receive and drops the link.
// RL4: At hardware reset speed loads 01 if autoneg enabled, else {0,strap}.
// RL5: Speed code 00 is 10 Mb/s, 01 is 100 Mb/s, 10 and 11 reserved.
// RL6: At hardware reset the autoneg enable bit loads from its strap.
// RL7: Autoneg enable is read/write; one enables autonegotiation.
// RL8: Leaving power-down triggers software reset and autoneg restart.
// RL9: Extended registers are reached via address port 29 and data port 30.
// RL10: Base indices decode as listed, with 18/19 irq and 21 rx errors.
// RL11: Power-down bit one enters power-down regardless of reset bits.
// RL12: Registers are 16 bits wide, indexed by the listed offset.
//
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/1ps
`include "phybc_regs.svh"

module phybc_bank (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Straps
    input  wire logic        speed_strap,
    input  wire logic        an_enable_strap,
    // PHY core side
    input  wire logic        rx_error_pulse,
    input  wire logic [15:0] partner_ability,
    input  wire logic [15:0] vendor_status,
    input  wire logic [15:0] cable_status,
    output logic             soft_reset,
    output logic             loopback_en,
    output logic             link_drop,
    output logic [1:0]       speed_sel,
    output logic             speed_reserved,
    output logic             an_enable,
    output logic             an_restart,
    output logic             power_down,
    // Interrupt
    output logic             irq
);

    phybc_pkg::phybc_state_type st_reg;
    phybc_pkg::phybc_state_type st_next;

    // Extended register storage
    logic [15:0] ext_mem_reg [0:`PHYBC_EXT_DEPTH-1];

    logic        req;
    logic        wr;
    logic        rd;
    logic [4:0]  idx;
    logic [15:0] wdat;
    logic [15:0] ctl_rd;
    logic [15:0] rd16;
    logic [2:0]  ext_idx;
    logic        sw_start;
    logic        rxerr_evt;

    // ------------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------------
    // One-cycle ack; request seen only while no ack is pending
    assign req     = wb_cyc_i & wb_stb_i & ~st_reg.ack;
    assign wr      = req & wb_we_i & (&wb_sel_i[1:0]);
    assign rd      = req & ~wb_we_i;
    assign idx     = wb_adr_i[6:2];
    assign wdat    = wb_dat_i[15:0];
    assign ext_idx = st_reg.ext_addr[2:0];
    assign rxerr_evt = st_reg.rxerr_s2 & ~st_reg.rxerr_s3;

    // Control register read image; reset bit always reads zero
    always_comb
    begin
        ctl_rd = 16'h0000;
        ctl_rd[`PHYBC_CTL_LOOPBACK]  = st_reg.loopback;
        ctl_rd[`PHYBC_CTL_SPEED_LSB] = st_reg.speed[0];
        ctl_rd[`PHYBC_CTL_SPEED_MSB] = st_reg.speed[1];
        ctl_rd[`PHYBC_CTL_AN_ENABLE] = st_reg.an_enable;
        ctl_rd[`PHYBC_CTL_PWR_DOWN]  = st_reg.pwr_down;
    end

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------
    always_comb
    begin
        case (idx) // RL10 RL12
            `PHYBC_IDX_BASIC_CONTROL:   rd16 = ctl_rd; // RL2
            `PHYBC_IDX_BASIC_STATUS:    rd16 = `PHYBC_STATUS_VALUE;
            `PHYBC_IDX_PHY_IDENT_HIGH:  rd16 = `PHYBC_IDENT_HIGH;
            `PHYBC_IDX_PHY_IDENT_LOW:   rd16 = `PHYBC_IDENT_LOW;
            `PHYBC_IDX_AN_ADVERTISE:    rd16 = st_reg.an_advertise;
            `PHYBC_IDX_PARTNER_ABILITY: rd16 = partner_ability;
            `PHYBC_IDX_AN_EXPANSION:    rd16 = 16'h0000;
            `PHYBC_IDX_VENDOR_CONTROL:  rd16 = st_reg.vendor_control;
            `PHYBC_IDX_VENDOR_STATUS:   rd16 = vendor_status;
            `PHYBC_IDX_IRQ_ENABLE:      rd16 = st_reg.irq_enable;
            `PHYBC_IDX_IRQ_STATUS:      rd16 = st_reg.irq_status;
            `PHYBC_IDX_DOWNSHIFT_CTRL:  rd16 = st_reg.downshift;
            `PHYBC_IDX_RX_ERROR_COUNT:  rd16 = st_reg.rx_err_cnt;
            `PHYBC_IDX_CABLE_TEST_CTRL: rd16 = st_reg.cable_ctrl;
            `PHYBC_IDX_LED_CONTROL:     rd16 = st_reg.led_ctrl;
            `PHYBC_IDX_LED_OVERRIDE:    rd16 = st_reg.led_ovr;
            `PHYBC_IDX_CABLE_TEST_STAT: rd16 = cable_status;
            `PHYBC_IDX_EXT_ADDRESS:     rd16 = st_reg.ext_addr; // RL9
            `PHYBC_IDX_EXT_DATA:        rd16 = ext_mem_reg[ext_idx]; // RL9
            5'h1F:                      rd16 = {13'h0000, st_reg.irq_sticky};
            default:                    rd16 = 16'h0000;
        endcase
        if (wb_adr_i[7])
        begin
            // Interrupt mask register sits above the PHY map
            rd16 = (idx == 5'h00) ? {13'h0000, st_reg.irq_mask} : 16'h0000;
        end
    end

    // Software reset start: write of one or leaving power-down
    assign sw_start = (wr & ~wb_adr_i[7] & (idx == `PHYBC_IDX_BASIC_CONTROL)
                       & wdat[`PHYBC_CTL_RESET]) // RL1
                    | (wr & ~wb_adr_i[7] & (idx == `PHYBC_IDX_BASIC_CONTROL)
                       & st_reg.pwr_down & ~wdat[`PHYBC_CTL_PWR_DOWN]); // RL8

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        st_next = st_reg;
        st_next.ack = req;
        st_next.rdata = {16'h0000, rd16};
        // Receive error pin synchroniser and edge
        st_next.rxerr_s1 = rx_error_pulse;
        st_next.rxerr_s2 = st_reg.rxerr_s1;
        st_next.rxerr_s3 = st_reg.rxerr_s2;
        // Straps caught once after reset release
        if (!st_reg.strap_done)
        begin
            st_next.strap_done = 1'b1;
            st_next.an_enable = an_enable_strap; // RL6
            st_next.speed = an_enable_strap ? `PHYBC_SPEED_100
                          : {1'b0, speed_strap}; // RL4
        end
        // Software reset pulse countdown
        if (st_reg.swrst_cnt != 3'h0)
        begin
            st_next.swrst_cnt = st_reg.swrst_cnt - 3'h1;
        end
        st_next.an_restart = 1'b0;
        // Register writes
        if (wr && !wb_adr_i[7])
        begin
            case (idx)
                `PHYBC_IDX_BASIC_CONTROL:
                begin
                    st_next.loopback  = wdat[`PHYBC_CTL_LOOPBACK]; // RL3
                    st_next.speed[0]  = wdat[`PHYBC_CTL_SPEED_LSB]; // RL5
                    st_next.an_enable = wdat[`PHYBC_CTL_AN_ENABLE]; // RL7
                    st_next.pwr_down  = wdat[`PHYBC_CTL_PWR_DOWN]; // RL11
                    st_next.an_restart = wdat[`PHYBC_CTL_AN_RESTRT];
                end
                `PHYBC_IDX_AN_ADVERTISE:    st_next.an_advertise = wdat;
                `PHYBC_IDX_VENDOR_CONTROL:  st_next.vendor_control = wdat;
                `PHYBC_IDX_IRQ_ENABLE:      st_next.irq_enable = wdat;
                `PHYBC_IDX_DOWNSHIFT_CTRL:  st_next.downshift = wdat;
                `PHYBC_IDX_CABLE_TEST_CTRL: st_next.cable_ctrl = wdat;
                `PHYBC_IDX_LED_CONTROL:     st_next.led_ctrl = wdat;
                `PHYBC_IDX_LED_OVERRIDE:    st_next.led_ovr = wdat;
                `PHYBC_IDX_EXT_ADDRESS:     st_next.ext_addr = wdat; // RL9
                default:                    ;
            endcase
        end
        if (wr && wb_adr_i[7] && idx == 5'h00)
        begin
            st_next.irq_mask = wdat[2:0];
        end
        // Software reset: load the pulse count, clear loopback, restart autoneg
        if (sw_start)
        begin
            st_next.swrst_cnt  = 3'(`PHYBC_SWRST_CYC); // RL1
            st_next.loopback   = 1'b0;
            st_next.an_restart = 1'b1; // RL8
        end
        // Clear-on-read then event sets, so an event wins over the clear
        if (rd && !wb_adr_i[7] && idx == `PHYBC_IDX_IRQ_STATUS)
        begin
            st_next.irq_status = 16'h0000;
        end
        if (rd && !wb_adr_i[7] && idx == 5'h1F)
        begin
            st_next.irq_sticky = 3'h0;
        end
        if (rxerr_evt)
        begin
            st_next.rx_err_cnt = st_reg.rx_err_cnt + 16'h0001; // RL10
            st_next.irq_status[`PHYBC_IRQ_RXERR] = 1'b1;
            st_next.irq_sticky[`PHYBC_IRQ_RXERR] = 1'b1;
        end
        if (sw_start)
        begin
            st_next.irq_sticky[`PHYBC_IRQ_SWRESET] = 1'b1;
        end
        if (st_reg.pwr_down && !st_next.pwr_down)
        begin
            st_next.irq_sticky[`PHYBC_IRQ_PWRUP] = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // Extended register writes through the data port
    always_ff @(posedge core_clk)
    begin
        if (wr && !wb_adr_i[7] && idx == `PHYBC_IDX_EXT_DATA)
        begin
            ext_mem_reg[ext_idx] <= wdat; // RL9
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign wb_ack_o       = st_reg.ack;
    assign wb_dat_o       = st_reg.rdata;
    assign soft_reset     = (st_reg.swrst_cnt != 3'h0); // RL1
    assign loopback_en    = st_reg.loopback; // RL3
    assign link_drop      = st_reg.loopback | st_reg.pwr_down; // RL3
    assign speed_sel      = st_reg.speed; // RL5
    assign speed_reserved = st_reg.speed[1]; // RL5
    assign an_enable      = st_reg.an_enable; // RL7
    assign an_restart     = st_reg.an_restart; // RL8
    assign power_down     = st_reg.pwr_down; // RL11
    assign irq            = |(st_reg.irq_sticky & st_reg.irq_mask);

endmodule : phybc_bank

// file: verilog/phybc_pkg.sv
// Types for the PHY register bank
package phybc_pkg;

    // Register bank state
    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
        logic        loopback;
        logic [1:0]  speed;
        logic        an_enable;
        logic        pwr_down;
        logic        an_restart;
        logic [2:0]  swrst_cnt;
        logic [15:0] an_advertise;
        logic [15:0] vendor_control;
        logic [15:0] irq_enable;
        logic [15:0] irq_status;
        logic [15:0] downshift;
        logic [15:0] rx_err_cnt;
        logic [15:0] cable_ctrl;
        logic [15:0] led_ctrl;
        logic [15:0] led_ovr;
        logic [15:0] ext_addr;
        logic [2:0]  irq_mask;
        logic [2:0]  irq_sticky;
        logic        rxerr_s1;
        logic        rxerr_s2;
        logic        rxerr_s3;
        logic        strap_done;
    } phybc_state_type;

endpackage : phybc_pkg

// file: verilog/phybc_regs.svh
// Offsets, field positions, reset values and timing counts for the PHY register bank
`ifndef PHYBC_REGS_SVH
`define PHYBC_REGS_SVH

// ---------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ---------------------------------------------------------------------------
`define PHYBC_IDX_BASIC_CONTROL   5'h00
`define PHYBC_IDX_BASIC_STATUS    5'h01
`define PHYBC_IDX_PHY_IDENT_HIGH  5'h02
`define PHYBC_IDX_PHY_IDENT_LOW   5'h03
`define PHYBC_IDX_AN_ADVERTISE    5'h04
`define PHYBC_IDX_PARTNER_ABILITY 5'h05
`define PHYBC_IDX_AN_EXPANSION    5'h06
`define PHYBC_IDX_VENDOR_CONTROL  5'h10
`define PHYBC_IDX_VENDOR_STATUS   5'h11
`define PHYBC_IDX_IRQ_ENABLE      5'h12
`define PHYBC_IDX_IRQ_STATUS      5'h13
`define PHYBC_IDX_DOWNSHIFT_CTRL  5'h14
`define PHYBC_IDX_RX_ERROR_COUNT  5'h15
`define PHYBC_IDX_CABLE_TEST_CTRL 5'h16
`define PHYBC_IDX_LED_CONTROL     5'h18
`define PHYBC_IDX_LED_OVERRIDE    5'h19
`define PHYBC_IDX_CABLE_TEST_STAT 5'h1C
`define PHYBC_IDX_EXT_ADDRESS     5'h1D
`define PHYBC_IDX_EXT_DATA        5'h1E

// ---------------------------------------------------------------------------
// Control register field positions
// ---------------------------------------------------------------------------
`define PHYBC_CTL_RESET     15
`define PHYBC_CTL_LOOPBACK  14
`define PHYBC_CTL_SPEED_LSB 13
`define PHYBC_CTL_AN_ENABLE 12
`define PHYBC_CTL_PWR_DOWN  11
`define PHYBC_CTL_AN_RESTRT 9
`define PHYBC_CTL_SPEED_MSB 6

// ---------------------------------------------------------------------------
// Reset values and constants
// ---------------------------------------------------------------------------
`define PHYBC_SPEED_10      2'h0
`define PHYBC_SPEED_100     2'h1
`define PHYBC_IRQ_BITS      3
`define PHYBC_IRQ_RXERR     0
`define PHYBC_IRQ_SWRESET   1
`define PHYBC_IRQ_PWRUP     2
// Identifier words: arbitrary values, not tied to any maker
`define PHYBC_IDENT_HIGH    16'h1234
`define PHYBC_IDENT_LOW     16'h5670
`define PHYBC_STATUS_VALUE  16'h7809
`define PHYBC_EXT_DEPTH     8
// Software reset pulse length
`define PHYBC_SWRST_NS      100
`define PHYBC_CLK_MHZ       50
`define PHYBC_SWRST_CYC     ((`PHYBC_SWRST_NS*`PHYBC_CLK_MHZ+999)/1000)

`endif
